// ### hw/bcm_pkg.sv
// Constants, types and register map of the boot configuration and memory-map block
package bcm_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_SPEED   = 16'hC008;
  localparam logic [15:0] IDX_GIE     = 16'hC00E;
  localparam logic [15:0] IDX_PAGE1   = 16'hC018;
  localparam logic [15:0] IDX_PAGE2   = 16'hC01A;
  localparam logic [15:0] IDX_XMC     = 16'hC03A;
  localparam logic [15:0] IDX_STATUS  = 16'hC040;

  // Reset and boot values
  localparam logic [15:0] SPEED_RST   = 16'h000F;
  localparam logic [15:0] SPEED_FULL  = 16'h0000;
  localparam logic [15:0] PC_RST      = 16'hFF00;
  localparam logic [15:0] PC_BOOT     = 16'hE000;
  localparam logic [15:0] PC_EXT_ROM  = 16'hC102;
  localparam logic [15:0] SP_BOOT     = 16'h0400;
  localparam logic [15:0] XMC_BOOT    = 16'h2777;
  localparam logic [15:0] PAGE1_BOOT  = 16'h0000;
  localparam logic [15:0] PAGE2_BOOT  = 16'h0001;

  // Boot signatures and probe locations
  localparam logic [15:0] ROM_SIG_ADDR = 16'hC100;
  localparam logic [15:0] SIG_JUMP     = 16'hCB36;
  localparam logic [15:0] SIG_SCAN     = 16'hC3B6;
  localparam logic [7:0]  SIG_LOW      = 8'hB6;
  localparam logic [15:0] RAM_PROBE    = 16'h6000;
  localparam logic [15:0] RAM_PATTERN  = 16'hA55A;

  // External memory control fields
  localparam int XMC_ROM8_BIT  = 7;
  localparam int XMC_RAM8_BIT  = 15;
  localparam int XMC_RAM_WS_LSB = 0;
  localparam int XMC_ROM_WS_LSB = 8;

  // Address map
  localparam int PAGE_W = 8;
  localparam int EXT_AW = 21;
  localparam int INT_AW = 14;
  localparam logic [2:0] WIN1_TAG = 3'h4;
  localparam logic [2:0] WIN2_TAG = 3'h5;

  // Timing
  localparam int CLK_PS        = 25000;
  localparam int WAIT_STATE_PS = 20800;
  localparam int WS_CYC        = (WAIT_STATE_PS + CLK_PS - 1) / CLK_PS;
  localparam int SYNC_LAT      = 2;
  localparam int HSS_BAUD      = 115200;

  // Strap codes {pin 30, pin 31}
  localparam logic [1:0] STRAP_HOST_PAR = 2'h0;
  localparam logic [1:0] STRAP_HS_SER   = 2'h1;
  localparam logic [1:0] STRAP_SER_PER  = 2'h2;
  localparam logic [1:0] STRAP_EEPROM   = 2'h3;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  typedef enum logic [14:0] {
    ST_HWRST   = 15'h0001, ST_JUMP    = 15'h0002, ST_STACK   = 15'h0004,
    ST_FULLSPD = 15'h0008, ST_XMCFG   = 15'h0010, ST_ROM16   = 15'h0020,
    ST_ROM8    = 15'h0040, ST_PAGES   = 15'h0080, ST_RAMWR   = 15'h0100,
    ST_RAMRD   = 15'h0200, ST_GIE     = 15'h0400, ST_INIT    = 15'h0800,
    ST_BOOTCTL = 15'h1000, ST_SCAN    = 15'h2000, ST_IDLE    = 15'h4000
  } bcm_state_t;

endpackage : bcm_pkg

// ### hw/bcm_boot_seq.sv
// Boot sequencer, external memory sizing, page windows and strap decode
//
// Overview of operation
// - Page register one maps window 0x8000-0x9FFF, page register two the second window.
// - The two windows together reach up to 2 MByte of extended memory.
// - Engine addresses reach internal memory only; 0x8000 aliases to 0x0000.
// - External RAM width found by writing then reading back a value.
// - With no SRAM answering, memory control is left in 8-bit setting.
// - External ROM boot only with signature 0xC3B6 or 0xCB36 at 0xC100.
// - Each space 8/16 bit, zero to seven wait states of 20.8ns each.
// - Hardware reset loads divider 0x000F and program counter 0xFF00.
// - Execution continues at 0xE000, then stack pointer becomes 0x400.
// - Divider then cleared for full speed; global interrupts disabled.
// - Memory control then written 0x2777: 16-bit ROM and RAM.
// - Signature 0xCB36 jumps to 0xC102 and skips the rest.
// - Byte-mode test showing only 0xB6 sets control bit 7.
// - Reduced-pin variant turns ROM pins to general I/O without signature.
// - Boot sets page register one to 0 and two to 1.
// - RAM at 0x6000 is probed and enabled as 8 or 16 bit.
// - Global interrupt enable cleared before the init steps run.
// - Scan call runs when 0xC3B6 found, then idle and wait.
// - Straps: 00 parallel, 01 fast serial, 10 serial peripheral, 11 stand-alone.
// - Role strap low selects host, high peripheral, for first engine.
// - Co-processor mode keeps USB ports off until the link enables them.
// - Stand-alone puts port C in peripheral mode; EEPROM may override A, C.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module bcm_boot_seq
  import bcm_pkg::*;
#(
  parameter bit REDUCED_PIN = 1'b0
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Strap pins
  input  wire logic                      boot_strap_a,
  input  wire logic                      boot_strap_b,
  input  wire logic                      dual_role_id_strap,
  // External memory bus
  output logic                           xm_req,
  output logic                           xm_we,
  output logic                           xm_byte,
  output logic [15:0]                    xm_addr,
  output logic [15:0]                    xm_wdata,
  input  wire logic [15:0]               xm_rdata,
  // Address translation
  input  wire logic [15:0]               cpu_addr,
  output logic [bcm_pkg::EXT_AW-1:0]     ext_addr,
  output logic                           ext_win_hit,
  input  wire logic [15:0]               dma_addr,
  output logic [bcm_pkg::INT_AW-1:0]     dma_iaddr,
  // Boot state
  output logic [15:0]                    boot_pc,
  output logic [15:0]                    stack_ptr,
  output logic [15:0]                    clock_divider,
  output logic                           global_int_en,
  output logic                           init_req,
  input  wire logic                      init_done,
  output logic                           scan_req,
  input  wire logic                      scan_done,
  output logic                           boot_done,
  output logic                           rom_pins_gpio,
  // Command port and USB set-up
  output logic [1:0]                     cmd_port_sel,
  output logic                           cmd_port_ready,
  input  wire logic                      link_usb_en,
  output logic                           usb_ports_en,
  output logic                           first_usb_interface_engine_host,
  output logic                           port_a_host,
  output logic                           port_c_host,
  input  wire logic                      eeprom_ovr,
  input  wire logic                      eeprom_a_host,
  input  wire logic                      eeprom_c_host
);
  import bcm_pkg::*;

  typedef struct packed {
    bcm_state_t            st;
    logic [15:0]           speed;
    logic [15:0]           gie;
    logic [15:0]           page1;
    logic [15:0]           page2;
    logic [15:0]           xmc;
    logic [15:0]           pc;
    logic [15:0]           sp;
    logic                  sa_a;
    logic                  sa_b;
    logic                  sb_a;
    logic                  sb_b;
    logic                  rid_a;
    logic                  rid_b;
    logic [15:0]           rd_a;
    logic [15:0]           rd_b;
    logic [4:0]            cnt;
    logic                  busy;
    logic [15:0]           rom_word;
    logic                  sig_scan;
    logic                  ext_jump;
    logic                  ram16;
    logic                  rom_gpio;
    logic                  done;
    logic                  standalone;
    logic                  eng1_host;
    logic                  ports_en;
    logic                  pa_host;
    logic                  pc_host;
    logic                  cmd_ready;
    logic [1:0]            strap;
    logic                  xm_req;
    logic                  xm_we;
    logic                  xm_byte;
    logic [15:0]           xm_addr;
    logic [15:0]           xm_wdata;
    logic                  init_req;
    logic                  scan_req;
    logic [EXT_AW-1:0]     ext_addr;
    logic                  win_hit;
    logic [INT_AW-1:0]     dma_iaddr;
    logic                  ap_valid;
    logic                  ap_write;
    logic [15:0]           ap_idx;
    logic [31:0]           hrdata;
    logic                  rdy;
  } bcm_regs_t;

  bcm_regs_t s_q;
  bcm_regs_t s_d;
  logic      mem_fin;

  // Launch one timed external cycle; the count covers the wait states plus the
  // two-stage pin synchroniser so the sampled word is settled when it ends.
  function automatic bcm_regs_t mem_go(input bcm_regs_t r, input logic [15:0] a,
                                       input logic we, input logic by,
                                       input logic [2:0] ws);
    bcm_regs_t o;
    o          = r;
    o.busy     = 1'b1;
    o.xm_req   = 1'b1;
    o.xm_addr  = a;
    o.xm_we    = we;
    o.xm_byte  = by;
    o.xm_wdata = RAM_PATTERN;
    o.cnt      = 5'(int'(ws) * WS_CYC + SYNC_LAT);
    return o;
  endfunction : mem_go

  always_comb begin
    s_d = s_q;
    mem_fin = 1'b0;
    s_d.rdy = 1'b1;
    // Pins pass two flip-flops before any logic looks at them
    s_d.sa_a  = boot_strap_a;
    s_d.sa_b  = s_q.sa_a;
    s_d.sb_a  = boot_strap_b;
    s_d.sb_b  = s_q.sb_a;
    s_d.rid_a = dual_role_id_strap;
    s_d.rid_b = s_q.rid_a;
    s_d.rd_a  = xm_rdata;
    s_d.rd_b  = s_q.rd_a;

    // Data phase of a software write; boot steps below override it
    if (s_q.ap_valid && s_q.ap_write) begin
      case (s_q.ap_idx)
        IDX_SPEED: s_d.speed = hwdata[15:0];
        IDX_GIE:   s_d.gie   = hwdata[15:0];
        IDX_PAGE1: s_d.page1 = hwdata[15:0];
        IDX_PAGE2: s_d.page2 = hwdata[15:0];
        IDX_XMC:   s_d.xmc   = hwdata[15:0];
        default: ;
      endcase
    end

    // Window translation, two pages of 8 KB each out of 2 MB
    s_d.win_hit = 1'b1;
    if (cpu_addr[15:13] == WIN1_TAG) begin
      s_d.ext_addr = {s_q.page1[PAGE_W-1:0], cpu_addr[12:0]};
    end else if (cpu_addr[15:13] == WIN2_TAG) begin
      s_d.ext_addr = {s_q.page2[PAGE_W-1:0], cpu_addr[12:0]};
    end else begin
      s_d.ext_addr = {{(EXT_AW - 16){1'b0}}, cpu_addr};
      s_d.win_hit  = 1'b0;
    end
    // No range check: upper bits dropped, so window addresses alias low
    s_d.dma_iaddr = dma_addr[INT_AW-1:0];

    // Timed external cycle, wait states from the control register
    if (s_q.busy) begin
      if (s_q.cnt == 5'h00) begin
        s_d.busy   = 1'b0;
        s_d.xm_req = 1'b0;
        s_d.xm_we  = 1'b0;
        mem_fin    = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 5'h01;
      end
    end

    // Boot steps, one after another
    unique case (s_q.st)
      ST_HWRST: begin
        s_d.pc    = PC_RST;
        s_d.speed = SPEED_RST;
        s_d.st    = ST_JUMP;
      end
      ST_JUMP: begin
        s_d.pc = PC_BOOT;
        s_d.st = ST_STACK;
      end
      ST_STACK: begin
        s_d.sp = SP_BOOT;
        s_d.st = ST_FULLSPD;
      end
      ST_FULLSPD: begin
        s_d.speed = SPEED_FULL;
        s_d.gie   = 16'h0000;
        s_d.st    = ST_XMCFG;
      end
      ST_XMCFG: begin
        s_d.xmc = XMC_BOOT;
        s_d.st  = ST_ROM16;
      end
      ST_ROM16: begin
        if (mem_fin) begin
          s_d.rom_word = s_q.rd_b;
          if (s_q.rd_b == SIG_JUMP) begin
            s_d.pc       = PC_EXT_ROM;
            s_d.ext_jump = 1'b1;
            s_d.done     = 1'b1;
            s_d.st       = ST_IDLE;
          end else begin
            s_d.st = ST_ROM8;
          end
        end else if (!s_q.busy) begin
          s_d = mem_go(s_d, ROM_SIG_ADDR, 1'b0, 1'b0, s_q.xmc[XMC_ROM_WS_LSB +: 3]);
        end
      end
      ST_ROM8: begin
        if (mem_fin) begin
          // Byte lane alone showing the low half means an 8-bit ROM
          if (s_q.rd_b[7:0] == SIG_LOW && s_q.rom_word != SIG_SCAN) begin
            s_d.xmc[XMC_ROM8_BIT] = 1'b1;
          end
          s_d.sig_scan = (s_q.rom_word == SIG_SCAN) || (s_q.rd_b[7:0] == SIG_LOW);
          if (REDUCED_PIN && !s_d.sig_scan) begin
            s_d.rom_gpio = 1'b1;
          end
          s_d.st = ST_PAGES;
        end else if (!s_q.busy) begin
          s_d = mem_go(s_d, ROM_SIG_ADDR, 1'b0, 1'b1, s_q.xmc[XMC_ROM_WS_LSB +: 3]);
        end
      end
      ST_PAGES: begin
        s_d.page1 = PAGE1_BOOT;
        s_d.page2 = PAGE2_BOOT;
        s_d.st    = ST_RAMWR;
      end
      ST_RAMWR: begin
        if (mem_fin) begin
          s_d.st = ST_RAMRD;
        end else if (!s_q.busy) begin
          s_d = mem_go(s_d, RAM_PROBE, 1'b1, 1'b0, s_q.xmc[XMC_RAM_WS_LSB +: 3]);
        end
      end
      ST_RAMRD: begin
        if (mem_fin) begin
          // Full word back means 16 bit; a torn or absent word leaves 8 bit
          s_d.ram16 = (s_q.rd_b == RAM_PATTERN);
          s_d.xmc[XMC_RAM8_BIT] = (s_q.rd_b != RAM_PATTERN);
          s_d.st = ST_GIE;
        end else if (!s_q.busy) begin
          s_d = mem_go(s_d, RAM_PROBE, 1'b0, 1'b0, s_q.xmc[XMC_RAM_WS_LSB +: 3]);
        end
      end
      ST_GIE: begin
        s_d.gie      = 16'h0000;
        s_d.init_req = 1'b1;
        s_d.st       = ST_INIT;
      end
      ST_INIT: begin
        if (init_done) begin
          s_d.init_req = 1'b0;
          s_d.st       = ST_BOOTCTL;
        end
      end
      ST_BOOTCTL: begin
        s_d.strap      = {s_q.sa_b, s_q.sb_b};
        s_d.standalone = ({s_q.sa_b, s_q.sb_b} == STRAP_EEPROM);
        s_d.eng1_host  = !s_q.rid_b;
        s_d.pa_host    = !s_q.rid_b;
        s_d.pc_host    = 1'b0;
        s_d.ports_en   = s_d.standalone;
        s_d.scan_req   = s_q.sig_scan;
        s_d.st         = s_q.sig_scan ? ST_SCAN : ST_IDLE;
      end
      ST_SCAN: begin
        if (scan_done) begin
          s_d.scan_req = 1'b0;
          s_d.st       = ST_IDLE;
        end
      end
      ST_IDLE: begin
        s_d.done      = 1'b1;
        s_d.cmd_ready = !s_q.standalone && !s_q.ext_jump;
        // Outside stand-alone only the external processor may turn the ports on
        if (s_q.cmd_ready && link_usb_en) begin
          s_d.ports_en = 1'b1;
        end
        if (s_q.standalone && eeprom_ovr) begin
          s_d.pa_host = eeprom_a_host;
          s_d.pc_host = eeprom_c_host;
        end
      end
      default: s_d.st = ST_HWRST;
    endcase

    // Address phase; read data comes from next values so a write just ahead
    // is seen, at the price of a longer path into hrdata.
    s_d.ap_valid = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    s_d.ap_write = hwrite;
    s_d.ap_idx   = (haddr[31:18] == 14'h0000) ? haddr[17:2] : 16'h0000;
    s_d.hrdata   = 32'h0000_0000;
    if (s_d.ap_valid && !hwrite) begin
      case (s_d.ap_idx)
        IDX_SPEED:  s_d.hrdata = {16'h0000, s_d.speed};
        IDX_GIE:    s_d.hrdata = {16'h0000, s_d.gie};
        IDX_PAGE1:  s_d.hrdata = {16'h0000, s_d.page1};
        IDX_PAGE2:  s_d.hrdata = {16'h0000, s_d.page2};
        IDX_XMC:    s_d.hrdata = {16'h0000, s_d.xmc};
        IDX_STATUS: s_d.hrdata = {22'h000000, s_d.ports_en, s_d.rom_gpio, s_d.ram16,
                                  s_d.rid_b, s_d.strap, s_d.standalone, s_d.sig_scan,
                                  s_d.ext_jump, s_d.done};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q       <= '0;
      s_q.st    <= ST_HWRST;
      s_q.speed <= SPEED_RST;
      s_q.pc    <= PC_RST;
      s_q.rdy   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout     = s_q.rdy;
  assign hresp         = 1'b0;
  assign hrdata        = s_q.hrdata;
  assign xm_req        = s_q.xm_req;
  assign xm_we         = s_q.xm_we;
  assign xm_byte       = s_q.xm_byte;
  assign xm_addr       = s_q.xm_addr;
  assign xm_wdata      = s_q.xm_wdata;
  assign ext_addr      = s_q.ext_addr;
  assign ext_win_hit   = s_q.win_hit;
  assign dma_iaddr     = s_q.dma_iaddr;
  assign boot_pc       = s_q.pc;
  assign stack_ptr     = s_q.sp;
  assign clock_divider = s_q.speed;
  assign global_int_en = s_q.gie[0];
  assign init_req      = s_q.init_req;
  assign scan_req      = s_q.scan_req;
  assign boot_done     = s_q.done;
  assign rom_pins_gpio = s_q.rom_gpio;
  assign cmd_port_sel  = s_q.strap;
  assign cmd_port_ready = s_q.cmd_ready;
  assign usb_ports_en  = s_q.ports_en;
  assign first_usb_interface_engine_host = s_q.eng1_host;
  assign port_a_host   = s_q.pa_host;
  assign port_c_host   = s_q.pc_host;

  a_reset_vector: assert property (@(posedge clock) disable iff (!nrst)
    s_q.st == ST_HWRST |-> s_q.speed == 16'h000F && s_q.pc == 16'hFF00)
    else $error("reset vector or divider wrong");

  a_jump_stack: assert property (@(posedge clock) disable iff (!nrst)
    s_q.st == ST_JUMP |=> s_q.pc == 16'hE000 ##1 s_q.sp == 16'h0400)
    else $error("boot entry or stack wrong");

  a_full_speed: assert property (@(posedge clock) disable iff (!nrst)
    s_q.st == ST_FULLSPD |=> s_q.speed == 16'h0000 && s_q.gie == 16'h0000)
    else $error("full speed step wrong");

  a_xmc_boot: assert property (@(posedge clock) disable iff (!nrst)
    s_q.st == ST_XMCFG |=> s_q.xmc == 16'h2777 && s_q.st == ST_ROM16)
    else $error("memory control boot value wrong");

  a_ext_jump: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s_q.ext_jump) |-> s_q.pc == 16'hC102 && s_q.st == ST_IDLE && !s_q.cmd_ready)
    else $error("signature jump wrong");

  a_pages_boot: assert property (@(posedge clock) disable iff (!nrst)
    s_q.st == ST_PAGES |=> s_q.page1 == 16'h0000 && s_q.page2 == 16'h0001)
    else $error("page registers boot value wrong");

  a_window_map: assert property (@(posedge clock) disable iff (!nrst)
    cpu_addr == 16'hA004 && s_q.page2 == 16'h0003 && !(s_q.ap_valid && s_q.ap_write)
    |=> ext_addr == 21'h006004 && ext_win_hit)
    else $error("second window translation wrong");

  a_dma_alias: assert property (@(posedge clock) disable iff (!nrst)
    dma_addr == 16'h8000 |=> dma_iaddr == 14'h0000)
    else $error("engine address alias wrong");

  a_mem_wait: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s_q.xm_req) |-> s_q.xm_req [*3])
    else $error("external cycle too short");

  a_cmd_after: assert property (@(posedge clock) disable iff (!nrst)
    s_q.cmd_ready |-> s_q.done && s_q.st == ST_IDLE && !s_q.init_req)
    else $error("command port ready before boot control");

  a_usb_off: assert property (@(posedge clock) disable iff (!nrst)
    $rose(s_q.cmd_ready) |-> !s_q.ports_en)
    else $error("usb ports on before link enable");

endmodule : bcm_boot_seq

// ### testbench/bcm_xmem_model.sv
// Model of external ROM and probe RAM on the memory bus
`timescale 1ns/1ps
module bcm_xmem_model
  import bcm_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Memory bus
  input  wire logic        xm_req,
  input  wire logic        xm_we,
  input  wire logic [15:0] xm_addr,
  input  wire logic [15:0] xm_wdata,
  output logic      [15:0] xm_rdata,
  // Fitted parts: RAM kind 0 none, 1 byte, 2 word
  input  wire logic [15:0] rom_word,
  input  wire logic [1:0]  ram_kind
);
  logic [15:0] ram_q  = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  logic        rd_rom;
  logic        rd_ram;
  assign rd_rom = xm_req && !xm_we && xm_addr == ROM_SIG_ADDR;
  assign rd_ram = xm_req && !xm_we && xm_addr == RAM_PROBE && ram_kind != 2'h0;
  // Undriven bus toggles so a stale value never passes as a match
  always_comb begin
    xm_rdata = ~last_q;
    if (rd_rom) xm_rdata = rom_word;
    if (rd_ram) xm_rdata = ram_q;
  end
  // Byte-wide part keeps only the low lane
  always @(posedge clock) begin
    last_q <= xm_rdata;
    if (xm_req && xm_we && xm_addr == RAM_PROBE)
      ram_q <= (ram_kind == 2'h2) ? xm_wdata : {~xm_wdata[15:8], xm_wdata[7:0]};
  end
endmodule : bcm_xmem_model

// ### testbench/tb.sv
// Self-checking bench for the boot sequencer and memory map
`timescale 1ns/1ps
module tb;
  import bcm_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, ram_kind = 2'h0, cmd_port_sel;
  logic        boot_strap_a = 1'b0, boot_strap_b = 1'b0, dual_role_id_strap = 1'b0;
  logic        init_done = 1'b0, scan_done = 1'b0, link_usb_en = 1'b0;
  logic        eeprom_ovr = 1'b0, eeprom_a_host = 1'b0, eeprom_c_host = 1'b0;
  logic [15:0] cpu_addr = 16'h0, dma_addr = 16'h0, rom_word = 16'h0;
  logic [15:0] xm_addr, xm_wdata, xm_rdata, boot_pc, stack_ptr, clock_divider;
  logic [20:0] ext_addr;
  logic [13:0] dma_iaddr;
  logic        hreadyout, hresp, xm_req, xm_we, xm_byte, ext_win_hit, global_int_en;
  logic        init_req, scan_req, boot_done, rom_pins_gpio, cmd_port_ready, usb_ports_en;
  logic        first_usb_interface_engine_host, port_a_host, port_c_host;
  int          n_fail = 0, checked = 0, xlen = 0, last_len = 0;

  always #12.5 clock = ~clock;
  assign hready = hreadyout;
  // Reduced-pin build so the ROM pin hand-over to general I/O is exercised
  bcm_boot_seq #(.REDUCED_PIN(1'b1)) uut (.*, .hsize(HSIZE_WORD));
  bcm_xmem_model mem (.*);

  // Length of the latest external cycle
  always @(posedge clock) begin
    if (xm_req === 1'b1) xlen <= xlen + 1;
    else if (xlen != 0) begin
      last_len <= xlen;
      xlen <= 0;
    end
  end

  task conclude;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk

  task rdy;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock);
      if (hready === 1'b1) return;
    end
    $display("[ERR] hready expected 1 seen 0");
    n_fail++;
    conclude();
  endtask : rdy

  task ahb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'h0};
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : ahb

  task boot(input logic [1:0] s, input logic id, input logic [15:0] rom,
            input logic [1:0] rk, input logic scan);
    int n;
    @(posedge clock);
    nrst <= 1'b0;
    {boot_strap_a, boot_strap_b} <= s;
    dual_role_id_strap <= id;
    rom_word <= rom;
    ram_kind <= rk;
    repeat (4) @(posedge clock);
    chk("divider in reset", 32'h000F, clock_divider);
    chk("pc in reset", 32'hFF00, boot_pc);
    nrst <= 1'b1;
    for (n = 0; n < 3000; n++) begin
      @(posedge clock);
      init_done <= init_req;
      if ((scan ? scan_req : boot_done) === 1'b1) break;
    end
    if (n == 3000) begin
      $display("[ERR] boot end expected 1 seen 0");
      n_fail++;
      conclude();
    end
    #1;
  endtask : boot

  task t_jump;
    boot(2'h2, 1'b0, 16'hCB36, 2'h2, 1'b0);
    chk("pc", 32'hC102, boot_pc);
    chk("cmd ready", 32'h0, cmd_port_ready);
    chk("ext cycle", 32'd10, last_len);
  endtask : t_jump

  task t_alone;
    logic [31:0] r;
    boot(2'h3, 1'b1, 16'hC3B6, 2'h2, 1'b1);
    chk("divider", 32'h0, clock_divider);
    chk("stack", 32'h400, stack_ptr);
    chk("gie", 32'h0, global_int_en);
    chk("usb on", 32'h1, usb_ports_en);
    chk("port c host", 32'h0, port_c_host);
    chk("port a host", 32'h0, port_a_host);
    chk("engine host", 32'h0, first_usb_interface_engine_host);
    chk("cmd ready", 32'h0, cmd_port_ready);
    chk("rom pins kept", 32'h0, rom_pins_gpio);
    ahb(1'b0, IDX_XMC, 32'h0, r);
    chk("xmc word", 32'h2777, r);
    ahb(1'b0, IDX_PAGE1, 32'h0, r);
    chk("page one", 32'h0, r);
    ahb(1'b0, IDX_PAGE2, 32'h0, r);
    chk("page two", 32'h1, r);
    scan_done <= 1'b1;
    @(posedge clock);
    scan_done <= 1'b0;
    #1;
    chk("scan req", 32'h0, scan_req);
    @(posedge clock);
    {eeprom_ovr, eeprom_a_host, eeprom_c_host} <= 3'h7;
    @(posedge clock);
    eeprom_ovr <= 1'b0;
    #1;
    chk("override c", 32'h1, port_c_host);
    chk("override a", 32'h1, port_a_host);
  endtask : t_alone

  task t_coproc;
    logic [31:0] r;
    for (int s = 0; s < 3; s++) begin
      boot(s[1:0], 1'b0, 16'h0000, 2'h0, 1'b0);
      chk("port sel", s, cmd_port_sel);
      chk("cmd ready", 32'h1, cmd_port_ready);
      chk("usb off", 32'h0, usb_ports_en);
      chk("rom pins gpio", 32'h1, rom_pins_gpio);
      chk("engine host", 32'h1, first_usb_interface_engine_host);
    end
    ahb(1'b0, IDX_XMC, 32'h0, r);
    chk("xmc no ram", 32'hA777, r);
    link_usb_en <= 1'b1;
    @(posedge clock);
    link_usb_en <= 1'b0;
    #1;
    chk("usb on", 32'h1, usb_ports_en);
  endtask : t_coproc

  task t_rom8;
    logic [31:0] r;
    boot(2'h1, 1'b1, 16'hFFB6, 2'h1, 1'b1);
    ahb(1'b0, IDX_XMC, 32'h0, r);
    chk("xmc byte parts", 32'hA7F7, r);
  endtask : t_rom8

  task t_map;
    logic [31:0] r;
    ahb(1'b1, IDX_PAGE1, 32'h12, r);
    ahb(1'b1, IDX_PAGE2, 32'hFF, r);
    ahb(1'b0, IDX_PAGE1, 32'h0, r);
    chk("page one", 32'h12, r);
    ahb(1'b0, 16'h0123, 32'h0, r);
    chk("unmapped", 32'h0, r);
    cpu_addr <= 16'h8ABC;
    dma_addr <= 16'h8000;
    @(posedge clock);
    cpu_addr <= 16'hA123;
    #1;
    chk("window one", 32'h24ABC, ext_addr);
    chk("dma alias", 32'h0, dma_iaddr);
    chk("window one hit", 32'h1, ext_win_hit);
    @(posedge clock);
    cpu_addr <= 16'h4000;
    #1;
    chk("window two", 32'h1FE123, ext_addr);
    @(posedge clock);
    #1;
    chk("no window", 32'h0, ext_win_hit);
    ahb(1'b1, IDX_PAGE2, 32'h3, r);
    cpu_addr <= 16'hA004;
    repeat (2) @(posedge clock);
    #1;
    chk("window two low", 32'h6004, ext_addr);
  endtask : t_map

  initial begin
    t_jump();
    t_alone();
    t_coproc();
    t_rom8();
    t_map();
    conclude();
  end
endmodule : tb
